// ### hdl/sync_timing_pkg.sv
// Package of register offsets, field layouts, reset values and states for the timing registers.
package sync_timing_pkg;

	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [7:0] OFS_LINK_A_SYNC_LAG_LOWER = 8'h28;
	localparam logic [7:0] OFS_LINK_A_SYNC_LAG_UPPER = 8'h29;
	localparam logic [7:0] OFS_LINK_B_SYNC_LAG_LOWER = 8'h2a;
	localparam logic [7:0] OFS_CHB_SYNC_DELAY_UPPER = 8'h2b;
	localparam logic [7:0] OFS_CHA_HSYNC_WIDTH_LOWER = 8'h2c;
	localparam logic [7:0] OFS_CHA_HSYNC_WIDTH_UPPER = 8'h2d;
	localparam logic [7:0] OFS_CHB_HSYNC_WIDTH_LOWER = 8'h2e;
	localparam logic [7:0] OFS_CHB_HSYNC_WIDTH_UPPER = 8'h2f;
	localparam logic [7:0] OFS_CHA_VSYNC_WIDTH_LOWER = 8'h30;
	localparam logic [7:0] OFS_CHA_VSYNC_WIDTH_UPPER = 8'h31;
	localparam logic [7:0] OFS_CHB_VSYNC_WIDTH_LOWER = 8'h32;
	localparam logic [7:0] OFS_CHB_VSYNC_WIDTH_UPPER = 8'h33;
	localparam logic [7:0] OFS_CHA_HORIZ_BACK_PORCH = 8'h34;
	localparam logic [7:0] OFS_CHB_HORIZ_BACK_PORCH = 8'h35;
	localparam logic [7:0] OFS_CHA_VERT_BACK_PORCH = 8'h36;
	localparam logic [7:0] OFS_CHB_VERT_BACK_PORCH = 8'h37;
	localparam logic [7:0] OFS_CHA_HORIZ_FRONT_PORCH = 8'h38;
	localparam logic [7:0] OFS_PATTERN_CTRL = 8'h3c;

	// ****************************************************************
	// Fields and values
	// ****************************************************************
	localparam int PATTERN_A_BIT = 4;
	localparam logic [7:0] NIBBLE_MASK = 8'h0f;
	localparam logic [7:0] PATTERN_MASK = 8'h10;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [1:0] MODE_TWO_STREAMS = 2'h2;
	localparam int SYNC_LAG_W = 12;
	localparam int PULSE_W = 10;
	localparam int FIXED_LATENCY = 10;
	localparam int MIN_SYNC_LAG = 32;
	localparam int LINE_CNT_W = 12;

	// Test pattern line and frame layout: active sizes are fed in as ports.
	typedef enum logic [3:0]
	{
		PH_SYNC = 4'b0001,
		PH_BACK = 4'b0010,
		PH_ACTIVE = 4'b0100,
		PH_FRONT = 4'b1000
	} phase_e;

endpackage : sync_timing_pkg

// ### hdl/sync_lag_line.sv
// Programmable delay line for an HSync and VSync pair.
module sync_lag_line
	import sync_timing_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Control
	input wire logic [sync_timing_pkg::SYNC_LAG_W-1:0] lag,
	// Sync in and out
	input wire logic hs_in,
	input wire logic vs_in,
	output logic hs_out,
	output logic vs_out
);

	localparam int DEPTH = (1 << SYNC_LAG_W) + FIXED_LATENCY;
	localparam int AW = SYNC_LAG_W + 1;

	// ****************************************************************
	// Storage
	// ****************************************************************
	// A circular buffer of sync bits; the read side trails the write side by the
	// programmed lag plus the fixed pipeline latency.
	logic [1:0] mem [0:DEPTH-1];
	logic [AW-1:0] wr_r;
	logic [AW-1:0] wr_nxt;
	logic [AW-1:0] rd_idx;
	logic [1:0] out_r;
	logic [1:0] out_nxt;
	logic full_r;
	logic full_nxt;

	// Entries above the write pointer hold nothing until the pointer has wrapped
	// once, so until then they read as idle syncs rather than unknown storage.
	always_comb
	begin
		wr_nxt = (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
		full_nxt = full_r || (wr_r == AW'(DEPTH - 1));
		if (wr_r >= AW'(FIXED_LATENCY) + AW'(lag))
		begin
			rd_idx = wr_r - AW'(FIXED_LATENCY) - AW'(lag);
			out_nxt = mem[rd_idx];
		end
		else
		begin
			rd_idx = AW'(DEPTH) + wr_r - AW'(FIXED_LATENCY) - AW'(lag);
			out_nxt = full_r ? mem[rd_idx] : 2'h0;
		end
	end

	always_ff @(posedge clk)
	begin
		mem[wr_r] <= {vs_in, hs_in};
		if (srst)
		begin
			wr_r <= '0;
			out_r <= 2'h0;
			full_r <= 1'b0;
		end
		else
		begin
			wr_r <= wr_nxt;
			out_r <= out_nxt;
			full_r <= full_nxt;
		end
	end

	assign hs_out = out_r[0];
	assign vs_out = out_r[1];

endmodule : sync_lag_line

// ### hdl/sync_porch_timing.sv
// Sync delay, pulse width and porch timing registers with sync forwarding and link A test pattern timing.
module sync_porch_timing
	import sync_timing_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Local register port
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Mode configuration from elsewhere in the device
	input wire logic dual_link_sel,
	input wire logic [1:0] chan_mode,
	// Active sizes for pattern timing
	input wire logic [11:0] pattern_line_len,
	input wire logic [11:0] pattern_frame_lines,
	// Received syncs from the serial input side
	input wire logic a_hs_in,
	input wire logic a_vs_in,
	input wire logic b_hs_in,
	input wire logic b_vs_in,
	// Panel link timing
	output logic a_hsync,
	output logic a_vsync,
	output logic a_active,
	output logic b_hsync,
	output logic b_vsync,
	output logic [9:0] a_hpulse_len,
	output logic [9:0] b_hpulse_len,
	output logic [9:0] a_vpulse_len,
	output logic [9:0] b_vpulse_len,
	output logic [7:0] a_line_lead,
	output logic [7:0] b_line_lead
);

	// ****************************************************************
	// Register file
	// ****************************************************************
	logic [7:0] lag_a_lo_r, lag_a_hi_r, lag_b_lo_r, lag_b_hi_r;
	logic [7:0] ha_lo_r, ha_hi_r, hb_lo_r, hb_hi_r;
	logic [7:0] va_lo_r, va_hi_r, vb_lo_r, vb_hi_r;
	logic [7:0] hbp_a_r, hbp_b_r, vbp_a_r, vbp_b_r, hfp_a_r, pat_r;
	logic [7:0] rdata_r, rdata_nxt;
	logic two_streams;

	assign two_streams = !dual_link_sel && (chan_mode == MODE_TWO_STREAMS);

	// Writes are single cycle; the nibble registers mask reserved bits at store time.
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			lag_a_lo_r <= REG_RESET;
			lag_a_hi_r <= REG_RESET;
			lag_b_lo_r <= REG_RESET;
			lag_b_hi_r <= REG_RESET;
			ha_lo_r <= REG_RESET;
			ha_hi_r <= REG_RESET;
			hb_lo_r <= REG_RESET;
			hb_hi_r <= REG_RESET;
			va_lo_r <= REG_RESET;
			va_hi_r <= REG_RESET;
			vb_lo_r <= REG_RESET;
			vb_hi_r <= REG_RESET;
			hbp_a_r <= REG_RESET;
			hbp_b_r <= REG_RESET;
			vbp_a_r <= REG_RESET;
			vbp_b_r <= REG_RESET;
			hfp_a_r <= REG_RESET;
			pat_r <= REG_RESET;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				OFS_LINK_A_SYNC_LAG_LOWER: lag_a_lo_r <= reg_wdata;
				OFS_LINK_A_SYNC_LAG_UPPER: lag_a_hi_r <= reg_wdata & NIBBLE_MASK;
				OFS_LINK_B_SYNC_LAG_LOWER: lag_b_lo_r <= reg_wdata;
				OFS_CHB_SYNC_DELAY_UPPER: lag_b_hi_r <= reg_wdata & NIBBLE_MASK;
				OFS_CHA_HSYNC_WIDTH_LOWER: ha_lo_r <= reg_wdata;
				OFS_CHA_HSYNC_WIDTH_UPPER: ha_hi_r <= reg_wdata & NIBBLE_MASK;
				OFS_CHB_HSYNC_WIDTH_LOWER: hb_lo_r <= reg_wdata;
				OFS_CHB_HSYNC_WIDTH_UPPER: hb_hi_r <= reg_wdata & NIBBLE_MASK;
				OFS_CHA_VSYNC_WIDTH_LOWER: va_lo_r <= reg_wdata;
				OFS_CHA_VSYNC_WIDTH_UPPER: va_hi_r <= reg_wdata & NIBBLE_MASK;
				OFS_CHB_VSYNC_WIDTH_LOWER: vb_lo_r <= reg_wdata;
				OFS_CHB_VSYNC_WIDTH_UPPER: vb_hi_r <= reg_wdata & NIBBLE_MASK;
				OFS_CHA_HORIZ_BACK_PORCH: hbp_a_r <= reg_wdata;
				OFS_CHB_HORIZ_BACK_PORCH: hbp_b_r <= reg_wdata;
				OFS_CHA_VERT_BACK_PORCH: vbp_a_r <= reg_wdata;
				OFS_CHB_VERT_BACK_PORCH: vbp_b_r <= reg_wdata;
				OFS_CHA_HORIZ_FRONT_PORCH: hfp_a_r <= reg_wdata;
				OFS_PATTERN_CTRL: pat_r <= reg_wdata & PATTERN_MASK;
				default: ;
			endcase
		end
	end

	always_comb
	begin
		case (reg_addr)
			OFS_LINK_A_SYNC_LAG_LOWER: rdata_nxt = lag_a_lo_r;
			OFS_LINK_A_SYNC_LAG_UPPER: rdata_nxt = lag_a_hi_r;
			OFS_LINK_B_SYNC_LAG_LOWER: rdata_nxt = lag_b_lo_r;
			OFS_CHB_SYNC_DELAY_UPPER: rdata_nxt = lag_b_hi_r;
			OFS_CHA_HSYNC_WIDTH_LOWER: rdata_nxt = ha_lo_r;
			OFS_CHA_HSYNC_WIDTH_UPPER: rdata_nxt = ha_hi_r;
			OFS_CHB_HSYNC_WIDTH_LOWER: rdata_nxt = hb_lo_r;
			OFS_CHB_HSYNC_WIDTH_UPPER: rdata_nxt = hb_hi_r;
			OFS_CHA_VSYNC_WIDTH_LOWER: rdata_nxt = va_lo_r;
			OFS_CHA_VSYNC_WIDTH_UPPER: rdata_nxt = va_hi_r;
			OFS_CHB_VSYNC_WIDTH_LOWER: rdata_nxt = vb_lo_r;
			OFS_CHB_VSYNC_WIDTH_UPPER: rdata_nxt = vb_hi_r;
			OFS_CHA_HORIZ_BACK_PORCH: rdata_nxt = hbp_a_r;
			OFS_CHB_HORIZ_BACK_PORCH: rdata_nxt = hbp_b_r;
			OFS_CHA_VERT_BACK_PORCH: rdata_nxt = vbp_a_r;
			OFS_CHB_VERT_BACK_PORCH: rdata_nxt = vbp_b_r;
			OFS_CHA_HORIZ_FRONT_PORCH: rdata_nxt = hfp_a_r;
			OFS_PATTERN_CTRL: rdata_nxt = pat_r;
			default: rdata_nxt = 8'h00;
		endcase
	end

	// ****************************************************************
	// Field selection per link
	// ****************************************************************
	logic [9:0] ha_len, hb_len, va_len, vb_len;
	logic [9:0] hpa_r, hpb_r, vpa_r, vpb_r;
	logic [7:0] lla_r, llb_r;
	logic [SYNC_LAG_W-1:0] lag_a, lag_b;

	always_comb
	begin
		ha_len = {ha_hi_r[1:0], ha_lo_r};
		hb_len = two_streams ? {hb_hi_r[1:0], hb_lo_r} : ha_len;
		va_len = {va_hi_r[1:0], va_lo_r};
		vb_len = two_streams ? {vb_hi_r[1:0], vb_lo_r} : va_len;
		lag_a = {lag_a_hi_r[3:0], lag_a_lo_r};
		lag_b = two_streams ? {lag_b_hi_r[3:0], lag_b_lo_r} : lag_a;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			hpa_r <= 10'h000;
			hpb_r <= 10'h000;
			vpa_r <= 10'h000;
			vpb_r <= 10'h000;
			lla_r <= 8'h00;
			llb_r <= 8'h00;
			rdata_r <= 8'h00;
		end
		else
		begin
			hpa_r <= ha_len;
			hpb_r <= hb_len;
			vpa_r <= va_len;
			vpb_r <= vb_len;
			lla_r <= hbp_a_r;
			llb_r <= two_streams ? hbp_b_r : hbp_a_r;
			rdata_r <= rdata_nxt;
		end
	end

	// ****************************************************************
	// Sync forwarding
	// ****************************************************************
	// Lags below the minimum are not clamped; the host must honour the floor.
	logic [1:0] a_s1_r, a_s2_r, b_s1_r, b_s2_r;
	logic a_hs_dly, a_vs_dly, b_hs_dly, b_vs_dly;

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			a_s1_r <= 2'h0;
			a_s2_r <= 2'h0;
			b_s1_r <= 2'h0;
			b_s2_r <= 2'h0;
		end
		else
		begin
			a_s1_r <= {a_vs_in, a_hs_in};
			a_s2_r <= a_s1_r;
			b_s1_r <= {b_vs_in, b_hs_in};
			b_s2_r <= b_s1_r;
		end
	end

	sync_lag_line u_lag_a (
		.clk(clk),
		.srst(srst),
		.lag(lag_a),
		.hs_in(a_s2_r[0]),
		.vs_in(a_s2_r[1]),
		.hs_out(a_hs_dly),
		.vs_out(a_vs_dly)
	);

	sync_lag_line u_lag_b (
		.clk(clk),
		.srst(srst),
		.lag(lag_b),
		.hs_in(b_s2_r[0]),
		.vs_in(b_s2_r[1]),
		.hs_out(b_hs_dly),
		.vs_out(b_vs_dly)
	);

	// ****************************************************************
	// Link A test pattern timing
	// ****************************************************************
	phase_e hph_r, hph_nxt, vph_r, vph_nxt;
	logic [LINE_CNT_W-1:0] hcnt_r, hcnt_nxt, vcnt_r, vcnt_nxt;
	logic line_end;
	logic pat_on;
	logic ahs_r, avs_r, aact_r, bhs_r, bvs_r;

	assign pat_on = pat_r[PATTERN_A_BIT];

	always_comb
	begin
		hph_nxt = hph_r;
		hcnt_nxt = hcnt_r + 1'b1;
		line_end = 1'b0;
		case (hph_r)
			PH_SYNC: if (hcnt_r + 1'b1 >= LINE_CNT_W'(ha_len))
			begin
				hph_nxt = PH_BACK;
				hcnt_nxt = '0;
			end
			PH_BACK: if (hcnt_r + 1'b1 >= LINE_CNT_W'(hbp_a_r))
			begin
				hph_nxt = PH_ACTIVE;
				hcnt_nxt = '0;
			end
			PH_ACTIVE: if (hcnt_r + 1'b1 >= pattern_line_len)
			begin
				hph_nxt = PH_FRONT;
				hcnt_nxt = '0;
			end
			PH_FRONT: if (hcnt_r + 1'b1 >= LINE_CNT_W'(hfp_a_r))
			begin
				hph_nxt = PH_SYNC;
				hcnt_nxt = '0;
				line_end = 1'b1;
			end
			default:
			begin
				hph_nxt = PH_SYNC;
				hcnt_nxt = '0;
			end
		endcase
		vph_nxt = vph_r;
		vcnt_nxt = vcnt_r;
		if (line_end)
		begin
			vcnt_nxt = vcnt_r + 1'b1;
			case (vph_r)
				PH_SYNC: if (vcnt_r + 1'b1 >= LINE_CNT_W'(va_len))
				begin
					vph_nxt = PH_BACK;
					vcnt_nxt = '0;
				end
				PH_BACK: if (vcnt_r + 1'b1 >= LINE_CNT_W'(vbp_a_r))
				begin
					vph_nxt = PH_ACTIVE;
					vcnt_nxt = '0;
				end
				PH_ACTIVE: if (vcnt_r + 1'b1 >= pattern_frame_lines)
				begin
					vph_nxt = PH_SYNC;
					vcnt_nxt = '0;
				end
				default:
				begin
					vph_nxt = PH_SYNC;
					vcnt_nxt = '0;
				end
			endcase
		end
		if (!pat_on)
		begin
			hph_nxt = PH_SYNC;
			vph_nxt = PH_SYNC;
			hcnt_nxt = '0;
			vcnt_nxt = '0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			hph_r <= PH_SYNC;
			vph_r <= PH_SYNC;
			hcnt_r <= '0;
			vcnt_r <= '0;
			ahs_r <= 1'b0;
			avs_r <= 1'b0;
			aact_r <= 1'b0;
			bhs_r <= 1'b0;
			bvs_r <= 1'b0;
		end
		else
		begin
			hph_r <= hph_nxt;
			vph_r <= vph_nxt;
			hcnt_r <= hcnt_nxt;
			vcnt_r <= vcnt_nxt;
			ahs_r <= pat_on ? (hph_r == PH_SYNC) : a_hs_dly;
			avs_r <= pat_on ? (vph_r == PH_SYNC) : a_vs_dly;
			aact_r <= pat_on && hph_r == PH_ACTIVE && vph_r == PH_ACTIVE;
			bhs_r <= b_hs_dly;
			bvs_r <= b_vs_dly;
		end
	end

	assign reg_rdata = rdata_r;
	assign a_hsync = ahs_r;
	assign a_vsync = avs_r;
	assign a_active = aact_r;
	assign b_hsync = bhs_r;
	assign b_vsync = bvs_r;
	assign a_hpulse_len = hpa_r;
	assign b_hpulse_len = hpb_r;
	assign a_vpulse_len = vpa_r;
	assign b_vpulse_len = vpb_r;
	assign a_line_lead = lla_r;
	assign b_line_lead = llb_r;

endmodule : sync_porch_timing

// ### bench/timing_checks_assertions.sv
// Concurrent checks on the ports of the timing register block.
module timing_checks
	import sync_timing_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Register port
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	// Mode
	input wire logic dual_link_sel,
	input wire logic [1:0] chan_mode,
	// Link timing
	input wire logic a_hsync,
	input wire logic a_active,
	input wire logic [9:0] a_hpulse_len,
	input wire logic [9:0] b_hpulse_len,
	input wire logic [9:0] a_vpulse_len,
	input wire logic [9:0] b_vpulse_len,
	input wire logic [7:0] a_line_lead,
	input wire logic [7:0] b_line_lead
);
	// ****************************************************************
	// Properties
	// ****************************************************************
	logic two;
	assign two = !dual_link_sel && chan_mode == MODE_TWO_STREAMS;
	default clocking @(posedge clk);
	endclocking
	default disable iff (srst);
	// A write to the same place in the next cycle overtakes the first, so it is left out.
	sequence wr_once(ofs);
		reg_wr && reg_addr == ofs ##1 !(reg_wr && reg_addr == ofs);
	endsequence
	property lands(ofs, f, m);
		wr_once(ofs) |=> f == ($past(reg_wdata, 2) & m);
	endproperty
	property mirror(x, y);
		!two && !$past(two) |-> x == y;
	endproperty
	nibble_rsvd_zero_a: assert property (reg_addr[0] && reg_addr inside {[8'h29:8'h33]}
		|=> reg_rdata[7:4] == 4'h0) else $error("reserved bits read nonzero");
	a_hlow_lands_a: assert property (lands(OFS_CHA_HSYNC_WIDTH_LOWER, a_hpulse_len[7:0], 8'hff))
		else $error("hsync width low byte not applied");
	a_hhigh_lands_a: assert property (lands(OFS_CHA_HSYNC_WIDTH_UPPER,
		{6'h0, a_hpulse_len[9:8]}, 8'h03)) else $error("hsync width top bits not applied");
	a_vlow_lands_a: assert property (lands(OFS_CHA_VSYNC_WIDTH_LOWER, a_vpulse_len[7:0], 8'hff))
		else $error("vsync width low byte not applied");
	a_lead_lands_a: assert property (lands(OFS_CHA_HORIZ_BACK_PORCH, a_line_lead, 8'hff))
		else $error("back porch not applied");
	b_hmirror_a: assert property (mirror(b_hpulse_len, a_hpulse_len))
		else $error("link b hsync width not from link a");
	b_vmirror_a: assert property (mirror(b_vpulse_len, a_vpulse_len))
		else $error("link b vsync width not from link a");
	b_lead_mirror_a: assert property (mirror(b_line_lead, a_line_lead))
		else $error("link b back porch not from link a");
	cover property (two && reg_wr && reg_addr == OFS_CHB_HSYNC_WIDTH_LOWER);
	cover property ($rose(a_active));
	cover property ($rose(a_hsync));
endmodule : timing_checks

bind sync_porch_timing timing_checks checks_i (.clk(clk), .srst(srst), .reg_wr(reg_wr),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.dual_link_sel(dual_link_sel), .chan_mode(chan_mode), .a_hsync(a_hsync),
	.a_active(a_active), .a_hpulse_len(a_hpulse_len), .b_hpulse_len(b_hpulse_len),
	.a_vpulse_len(a_vpulse_len), .b_vpulse_len(b_vpulse_len), .a_line_lead(a_line_lead),
	.b_line_lead(b_line_lead));

// ### bench/panel_rx.sv
// Panel side model that measures line timing phases in pixel clocks.
module panel_rx
(
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Link timing at the panel
	input wire logic hsync,
	input wire logic active,
	// Measured lengths
	output logic [15:0] hs_w,
	output logic [15:0] act_w,
	output logic [15:0] bp_w,
	output logic [15:0] fp_w
);
	timeunit 1ns;
	timeprecision 1ps;
	logic hs_r;
	logic act_r;
	logic tail_r;
	logic [15:0] run_r;
	// Front porch is only taken after an active line, since blank lines give no active edge to start it from.
	always_ff @(posedge clk)
	begin
		hs_r <= hsync;
		act_r <= active;
		run_r <= (hsync != hs_r || active != act_r) ? 16'h1 : run_r + 16'h1;
		if (!hsync && hs_r)
			hs_w <= run_r;
		if (active && !act_r)
			bp_w <= run_r;
		if (!active && act_r)
			act_w <= run_r;
		if (hsync && !hs_r && tail_r)
			fp_w <= run_r;
		tail_r <= (!active && act_r) ? 1'b1 : ((hsync && !hs_r) ? 1'b0 : tail_r);
		if (srst)
		begin
			hs_w <= 16'h0;
			act_w <= 16'h0;
			bp_w <= 16'h0;
			fp_w <= 16'h0;
			tail_r <= 1'b0;
		end
	end
endmodule : panel_rx

// ### bench/lvds_sync_porch_timing_regs_bench.sv
// Self-checking bench for the sync and porch timing registers.
module lvds_sync_porch_timing_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import sync_timing_pkg::*;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic reg_wr = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic dual_link_sel = 1'b1;
	logic [1:0] chan_mode = 2'h0;
	logic a_hs_in = 1'b0;
	logic b_hs_in = 1'b0;
	logic [7:0] reg_rdata, a_line_lead, b_line_lead;
	logic a_hsync, a_vsync, a_active, b_hsync, b_vsync;
	logic [9:0] a_hpulse_len, b_hpulse_len, a_vpulse_len, b_vpulse_len;
	logic [15:0] hs_w, act_w, bp_w, fp_w;
	int error_cnt = 0;
	int n_tests = 0;
	int cyc = 0;
	always #2.5 clk = ~clk;
	sync_porch_timing uut (.clk(clk), .srst(srst), .reg_wr(reg_wr), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .dual_link_sel(dual_link_sel),
		.chan_mode(chan_mode), .pattern_line_len(12'h008), .pattern_frame_lines(12'h004),
		.a_hs_in(a_hs_in), .a_vs_in(a_hs_in), .b_hs_in(b_hs_in), .b_vs_in(b_hs_in),
		.a_hsync(a_hsync), .a_vsync(a_vsync), .a_active(a_active), .b_hsync(b_hsync),
		.b_vsync(b_vsync), .a_hpulse_len(a_hpulse_len), .b_hpulse_len(b_hpulse_len),
		.a_vpulse_len(a_vpulse_len), .b_vpulse_len(b_vpulse_len), .a_line_lead(a_line_lead),
		.b_line_lead(b_line_lead));
	panel_rx panel (.clk(clk), .srst(srst), .hsync(a_hsync), .active(a_active), .hs_w(hs_w),
		.act_w(act_w), .bp_w(bp_w), .fp_w(fp_w));
	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task final_report;
		$display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : final_report
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			final_report();
		end
	end
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		@(negedge clk);
		d = reg_rdata;
	endtask : rd
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task test_regs;
		logic [7:0] a;
		logic [7:0] d;
		logic [7:0] e;
		chk(16'(a_hpulse_len), 16'h0);
		for (int i = 'h2b; i <= 'h39; i++)
		begin
			a = 8'(i);
			e = a ^ 8'ha5;
			if (a[0] && a < 8'h34)
				e = e & 8'h0f;
			if (a == 8'h39)
				e = 8'h00;
			rd(a, d);
			chk(16'(d), 16'h0);
			wr(a, a ^ 8'ha5);
			rd(a, d);
			chk(16'(d), 16'(e));
		end
		$display("test_regs done");
	endtask : test_regs
	task test_fields;
		logic two;
		wr(8'h2c, 8'h5a);
		wr(8'h2d, 8'hfe);
		wr(8'h30, 8'h3c);
		wr(8'h31, 8'h01);
		wr(8'h34, 8'h21);
		wr(8'h2e, 8'h96);
		wr(8'h2f, 8'h03);
		wr(8'h32, 8'h07);
		wr(8'h33, 8'h02);
		wr(8'h35, 8'h44);
		for (int k = 0; k < 5; k++)
		begin
			@(negedge clk);
			dual_link_sel = (k == 4);
			chan_mode = (k == 4) ? 2'h2 : 2'(k);
			two = (k == 2);
			repeat (3) @(negedge clk);
			chk(16'(a_hpulse_len), 16'h25a);
			chk(16'(a_vpulse_len), 16'h13c);
			chk(16'(a_line_lead), 16'h21);
			chk(16'(b_hpulse_len), two ? 16'h396 : 16'h25a);
			chk(16'(b_vpulse_len), two ? 16'h207 : 16'h13c);
			chk(16'(b_line_lead), two ? 16'h44 : 16'h21);
		end
		$display("test_fields done");
	endtask : test_fields
	task test_lag(input logic dl, input logic [1:0] cm, input logic use_b, input int lag);
		int d;
		@(negedge clk);
		dual_link_sel = dl;
		chan_mode = cm;
		repeat (4) @(negedge clk);
		if (use_b)
			b_hs_in = 1'b1;
		else
			a_hs_in = 1'b1;
		d = 0;
		while ((use_b ? b_hsync : a_hsync) !== 1'b1 && d < 700)
		begin
			@(negedge clk);
			d++;
		end
		chk(16'(d >= lag + 10 && d <= lag + 16), 16'h1);
		chk(16'(use_b ? b_vsync : a_vsync), 16'h1);
		a_hs_in = 1'b0;
		b_hs_in = 1'b0;
		repeat (lag + 40) @(negedge clk);
		chk(16'(use_b ? b_hsync : a_hsync), 16'h0);
		$display("test_lag done");
	endtask : test_lag
	task test_pattern;
		logic [7:0] d;
		int n;
		wr(8'h2c, 8'h03);
		wr(8'h2d, 8'h00);
		wr(8'h34, 8'h02);
		wr(8'h38, 8'h01);
		wr(8'h30, 8'h01);
		wr(8'h31, 8'h00);
		wr(8'h36, 8'h01);
		wr(8'h3c, 8'hff);
		rd(8'h3c, d);
		chk(16'(d), 16'h10);
		repeat (200) @(negedge clk);
		chk(hs_w, 16'h3);
		chk(bp_w, 16'h2);
		chk(act_w, 16'h8);
		chk(fp_w, 16'h1);
		n = 0;
		while (a_vsync !== 1'b0 && n < 200)
		begin
			@(negedge clk);
			n++;
		end
		while (a_vsync !== 1'b1 && n < 200)
		begin
			@(negedge clk);
			n++;
		end
		n = 0;
		while (a_vsync === 1'b1 && n < 200)
		begin
			@(negedge clk);
			n++;
		end
		chk(16'(n), 16'd14);
		n = 0;
		while (a_vsync === 1'b0 && n < 200)
		begin
			@(negedge clk);
			n++;
		end
		chk(16'(n), 16'd70);
		wr(8'h3c, 8'h00);
		repeat (30) @(negedge clk);
		chk(16'(a_active), 16'h0);
		$display("test_pattern done");
	endtask : test_pattern
	initial
	begin
		repeat (4) @(negedge clk);
		srst = 1'b0;
		test_regs();
		test_fields();
		wr(8'h28, 8'h40);
		wr(8'h29, 8'hf0);
		wr(8'h2a, 8'h30);
		wr(8'h2b, 8'hf1);
		test_lag(1'b1, 2'h0, 1'b0, 64);
		test_lag(1'b0, 2'h2, 1'b1, 304);
		test_lag(1'b0, 2'h1, 1'b1, 64);
		test_pattern();
		final_report();
	end
endmodule : lvds_sync_porch_timing_regs_bench
